// *** core/eeec_cfg.svh ***
// Constants of the external edge event controller: counts, widths, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef EEEC_CFG_SVH
`define EEEC_CFG_SVH

// ****************************************
// Line counts and selector widths
// ****************************************
`define EEEC_NUM_LINES     19
`define EEEC_NUM_PIN_LINES 16
`define EEEC_NUM_AUX_LINES 3
`define EEEC_NUM_GPIO      112
`define EEEC_SEL_W         7
`define EEEC_TRIG_W        2

// ****************************************
// Reset values
// ****************************************
`define EEEC_PEND_RST      19'h00000
`define EEEC_EVT_RST       19'h00000
`define EEEC_TOG_RST       1'h0
`define EEEC_IRQ_RST       1'h0

`endif

// *** core/eeec_pkg.sv ***
// Types shared by the external edge event controller modules.
// Assumes eeec_cfg.svh is on the include path.
`include "eeec_cfg.svh"

package eeec_pkg;

  // ****************************************
  // Trigger selection of one line
  // ****************************************
  typedef enum logic [`EEEC_TRIG_W-1:0] {
    EEEC_TRIG_OFF  = 2'h0,
    EEEC_TRIG_RISE = 2'h1,
    EEEC_TRIG_FALL = 2'h2,
    EEEC_TRIG_BOTH = 2'h3
  } eeec_trig_type;

  typedef logic [`EEEC_NUM_LINES-1:0] eeec_lines_type;

endpackage

// *** core/eeec_evt_if.sv ***
// Carrier of synchronised edge pulses from the capture stage to the top.
// Assumes both ends run on the same mclk.
`timescale 1ns/1ps

`include "eeec_cfg.svh"

interface eeec_evt_if #(
  parameter int NUM_LINES = `EEEC_NUM_LINES
);
  logic [NUM_LINES-1:0] rise_evt;  // One-cycle pulse per rising edge
  logic [NUM_LINES-1:0] fall_evt;  // One-cycle pulse per falling edge

  modport src (output rise_evt, output fall_evt);
  modport dst (input rise_evt, input fall_evt);
endinterface

// *** core/eeec_edge_capture.sv ***
// Edge capture of every line: asynchronous toggle cells, then synchronisers.
// Assumes line inputs may pulse narrower than one mclk period.
`timescale 1ns/1ps

`include "eeec_cfg.svh"

module eeec_edge_capture
  import eeec_pkg::*;
#(
  parameter int NUM_LINES = `EEEC_NUM_LINES
) (
  input  wire logic                 mclk_in,    // System clock
  input  wire logic                 resetn_in,  // Async reset, active low
  input  wire logic [NUM_LINES-1:0] line_in,    // Raw line levels
  eeec_evt_if.src                   evt         // Synchronised edge pulses
);

  // ****************************************
  // Per-line capture and synchroniser
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      logic rise_tog;
      logic fall_tog;
      logic next_rise_tog;
      logic next_fall_tog;
      logic [2:0] rise_sync;
      logic [2:0] fall_sync;
      logic [2:0] next_rise_sync;
      logic [2:0] next_fall_sync;

      // Toggle on the line's own edge; no mclk edge is needed to catch it
      always_comb begin
        next_rise_tog = ~rise_tog;
        next_fall_tog = ~fall_tog;
      end

      always_ff @(posedge line_in[gi] or negedge resetn_in) begin
        if (!resetn_in) begin
          rise_tog <= `EEEC_TOG_RST;
        end else begin
          rise_tog <= next_rise_tog;
        end
      end

      always_ff @(negedge line_in[gi] or negedge resetn_in) begin
        if (!resetn_in) begin
          fall_tog <= `EEEC_TOG_RST;
        end else begin
          fall_tog <= next_fall_tog;
        end
      end

      // Stage 0 is read only by stage 1, keeping metastability contained
      always_comb begin
        next_rise_sync = {rise_sync[1:0], rise_tog};
        next_fall_sync = {fall_sync[1:0], fall_tog};
      end

      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          rise_sync <= 3'h0;
          fall_sync <= 3'h0;
        end else begin
          rise_sync <= next_rise_sync;
          fall_sync <= next_fall_sync;
        end
      end

      // A toggle seen between stages 1 and 2 is one detected edge
      assign evt.rise_evt[gi] = rise_sync[2] ^ rise_sync[1];
      assign evt.fall_evt[gi] = fall_sync[2] ^ fall_sync[1];
    end
  endgenerate

endmodule

// *** core/eeec_top.sv ***
// External edge event controller: nineteen edge lines, masks, pending bits.
// Assumes controls are static or changed with the affected line masked.
//
// Notes on behaviour
// - Nineteen independent lines, each able to raise an interrupt or an event.
// - Each line selects rising edge, falling edge or both as its trigger.
// - Each line has its own mask, independent of every other line.
// - A pending register holds one bit per line with an outstanding request.
// - Pulses shorter than one clock period are caught by an asynchronous latch.
// - Any of 112 GPIO pins can feed each of the sixteen pin lines.
`timescale 1ns/1ps

`include "eeec_cfg.svh"

module eeec_top
  import eeec_pkg::*;
#(
  parameter int NUM_LINES     = `EEEC_NUM_LINES,
  parameter int NUM_PIN_LINES = `EEEC_NUM_PIN_LINES,
  parameter int NUM_GPIO      = `EEEC_NUM_GPIO,
  parameter int SEL_W         = `EEEC_SEL_W
) (
  input  wire logic                                  mclk_in,          // 100 MHz clock
  input  wire logic                                  resetn_in,        // Async reset, low
  input  wire logic [NUM_GPIO-1:0]                   gpio_in,          // GPIO pin levels
  input  wire logic [NUM_PIN_LINES*SEL_W-1:0]        pin_sel_in,       // Pin index per line
  input  wire logic [NUM_LINES-NUM_PIN_LINES-1:0]    aux_line_in,      // Internal lines
  input  wire logic [NUM_LINES*`EEEC_TRIG_W-1:0]     trig_sel_in,      // Trigger per line
  input  wire logic [NUM_LINES-1:0]                  int_unmask_in,    // 1 lets irq through
  input  wire logic [NUM_LINES-1:0]                  evt_unmask_in,    // 1 lets event through
  input  wire logic [NUM_LINES-1:0]                  sw_trig_in,       // Software request
  input  wire logic [NUM_LINES-1:0]                  pend_clear_in,    // Write-one clear
  output logic      [NUM_LINES-1:0]                  pending_out,      // Pending bits
  output logic                                       irq_out,          // Any pending
  output logic      [NUM_LINES-1:0]                  evt_out           // Event pulses
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // Refused at elaboration: the aux port needs at least one line of its own
  if (NUM_PIN_LINES >= NUM_LINES || NUM_PIN_LINES < 1) begin : g_bad_lines
    $error("eeec_top: pin line count must leave at least one aux line");
  end

  // Every pin must be reachable through one selector field
  if (NUM_GPIO > (1 << SEL_W) || NUM_GPIO < 1) begin : g_bad_pins
    $error("eeec_top: selector too narrow for the pin count");
  end

  // ****************************************
  // Pin selection
  // ****************************************
  logic [NUM_LINES-1:0] line_level;

  // Plain mux feeds the async cells; changing a selector may cause a
  // spurious edge, so mask the line while its selector is rewritten.
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PIN_LINES; gp++) begin : g_pin
      logic [SEL_W-1:0] sel;
      assign sel = pin_sel_in[gp*SEL_W +: SEL_W];
      // Out-of-range index reads low, so the line simply stays quiet
      assign line_level[gp] = (int'(sel) < NUM_GPIO) ? gpio_in[sel] : 1'b0;
    end
  endgenerate

  assign line_level[NUM_LINES-1:NUM_PIN_LINES] = aux_line_in;

  // ****************************************
  // Edge capture
  // ****************************************
  eeec_evt_if #(.NUM_LINES(NUM_LINES)) evt_bus ();

  eeec_edge_capture #(
    .NUM_LINES (NUM_LINES)
  ) u_capture (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .line_in   (line_level),
    .evt       (evt_bus.src)
  );

  // ****************************************
  // Trigger qualification
  // ****************************************
  logic [NUM_LINES-1:0] hit;

  genvar gt;
  generate
    for (gt = 0; gt < NUM_LINES; gt++) begin : g_trig
      eeec_trig_type trig;
      assign trig = eeec_trig_type'(trig_sel_in[gt*`EEEC_TRIG_W +: `EEEC_TRIG_W]);
      // Rise and fall bits of the encoding enable each edge kind
      assign hit[gt] = (evt_bus.rise_evt[gt] && trig[0])
                     || (evt_bus.fall_evt[gt] && trig[1])
                     || sw_trig_in[gt];
    end
  endgenerate

  // ****************************************
  // Pending, interrupt and event state
  // ****************************************
  logic [NUM_LINES-1:0] pending;
  logic [NUM_LINES-1:0] next_pending;
  logic [NUM_LINES-1:0] evt_pulse;
  logic [NUM_LINES-1:0] next_evt_pulse;
  logic                 irq;
  logic                 next_irq;

  // New hit wins over a clear in the same cycle so no request is lost
  always_comb begin
    next_pending   = (pending & ~pend_clear_in)
                   | (hit & int_unmask_in);
    next_evt_pulse = hit & evt_unmask_in;
    next_irq       = |next_pending;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending   <= NUM_LINES'(`EEEC_PEND_RST);
      evt_pulse <= NUM_LINES'(`EEEC_EVT_RST);
      irq       <= `EEEC_IRQ_RST;
    end else begin
      pending   <= next_pending;
      evt_pulse <= next_evt_pulse;
      irq       <= next_irq;
    end
  end

  // Outputs straight from flip-flops
  assign pending_out = pending;
  assign evt_out     = evt_pulse;
  assign irq_out     = irq;

endmodule

// *** verif/eeec_props.sv ***
// Checker of the edge event controller, watching the top ports only.
// Assumes a bind onto eeec_top with its default line counts.
`timescale 1ns/1ps

module eeec_props (
  input  wire logic         mclk_in,        // System clock
  input  wire logic         resetn_in,      // Async reset, active low
  input  wire logic [111:0] gpio_in,        // Pin levels
  input  wire logic [111:0] pin_sel_in,     // Pin index per line
  input  wire logic [37:0]  trig_sel_in,    // Trigger per line
  input  wire logic [18:0]  int_unmask_in,  // Pending enables
  input  wire logic [18:0]  evt_unmask_in,  // Event enables
  input  wire logic [18:0]  sw_trig_in,     // Software hits
  input  wire logic [18:0]  pend_clear_in,  // Write-one clear
  input  wire logic [18:0]  pending_out,    // Pending bits
  input  wire logic         irq_out,        // Any pending
  input  wire logic [18:0]  evt_out         // Event pulses
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  irq_any_a: assert property (irq_out == (|pending_out))
    else $error("irq differs from the OR of pending bits");
  sw_set_a: assert property (
    (sw_trig_in & int_unmask_in) != 0 |=>
    (pending_out & $past(sw_trig_in & int_unmask_in)) == $past(sw_trig_in & int_unmask_in))
    else $error("software hit did not set pending");
  evt_set_a: assert property (
    (sw_trig_in & evt_unmask_in) != 0 |=>
    (evt_out & $past(sw_trig_in & evt_unmask_in)) == $past(sw_trig_in & evt_unmask_in))
    else $error("software hit did not pulse event");
  pend_hold_a: assert property (
    (pending_out & $past(pending_out & ~pend_clear_in)) == $past(pending_out & ~pend_clear_in))
    else $error("pending bit dropped without a clear");
  int_mask_a: assert property (
    (pending_out & ~$past(pending_out) & ~$past(int_unmask_in)) == 19'h00000)
    else $error("masked line set pending");
  evt_mask_a: assert property ((evt_out & ~$past(evt_unmask_in)) == 19'h00000)
    else $error("masked line pulsed event");
  rise_pend_a: assert property (
    $rose(gpio_in[pin_sel_in[6:0]]) && trig_sel_in[1:0] == 2'h1 && int_unmask_in[0]
    |-> ##[1:3] pending_out[0])
    else $error("rising edge on line 0 not latched in time");
endmodule

bind eeec_top eeec_props chk (.mclk_in, .resetn_in, .gpio_in, .pin_sel_in, .trig_sel_in,
  .int_unmask_in, .evt_unmask_in, .sw_trig_in, .pend_clear_in, .pending_out, .irq_out,
  .evt_out);

// *** verif/eeec_pin_model.sv ***
// Model of the GPIO pins feeding the controller.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps

module eeec_pin_model (
  input  wire logic         mclk_in,   // System clock
  output logic      [111:0] gpio_out   // Pin levels
);
  initial gpio_out = '0;

  // Level change launched on an edge, held until the next call
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge mclk_in);
    gpio_out[idx] <= lvl;
  endtask

  // Glitch of 3 ns between edges, too short for plain sampling
  task automatic short_pulse(input int idx);
    @(negedge mclk_in);
    gpio_out[idx] = 1'b1;
    #3;
    gpio_out[idx] = 1'b0;
  endtask
endmodule

// *** verif/tb_eeec_top.sv ***
// Self-checking bench of the edge event controller.
// Assumes eeec_props is bound and the pin model drives the GPIO pins.
`timescale 1ns/1ps

module tb_eeec_top;
  logic         mclk_in   = 1'b0;
  logic         resetn_in = 1'b0;
  logic [111:0] sel       = '0;
  logic [2:0]   aux       = '0;
  logic [37:0]  trig      = '0;
  logic [18:0]  imask     = 19'h7FFDF;
  logic [18:0]  emask     = 19'h7FFFF;
  logic [18:0]  sw        = '0;
  logic [18:0]  clr       = '0;
  logic [111:0] gpio;
  logic [18:0]  pend;
  logic [18:0]  evt;
  logic         irq;
  int           err_total = 0;
  int           cmp_count = 0;
  int           cycles    = 0;

  always #5 mclk_in = ~mclk_in;

  eeec_pin_model pins (.mclk_in(mclk_in), .gpio_out(gpio));
  eeec_top dut (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .gpio_in(gpio), .pin_sel_in(sel), .aux_line_in(aux), .trig_sel_in(trig),
    .int_unmask_in(imask), .evt_unmask_in(emask), .sw_trig_in(sw), .pend_clear_in(clr),
    .pending_out(pend), .irq_out(irq), .evt_out(evt));

  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly 125 cycles the tests need
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task automatic chk(input logic [18:0] got, input logic [18:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write-one clear of every line, then both pending and irq must be low
  task automatic clear_all();
    cyc(1);
    clr <= 19'h7FFFF;
    cyc(1);
    clr <= 19'h00000;
    cyc(1);
    #1;
    chk(pend | {18'h0, irq}, 19'h00000);
  endtask

  initial begin
    cyc(20);
    resetn_in <= 1'b1;
    cyc(1);
    #1;
    chk(pend | evt, 19'h00000);
    // Every trigger mode on line 0, each from another pin up to the last
    for (int m = 0; m < 4; m++) begin
      cyc(1);
      trig[1:0] <= m[1:0];
      sel[6:0] <= 7'(36 * m + 3);
      pins.set_pin(36 * m + 3, 1'b1);
      cyc(5);
      #1;
      chk(pend, {18'h0, m[0]});
      clear_all();
      pins.set_pin(36 * m + 3, 1'b0);
      cyc(5);
      #1;
      chk(pend, {18'h0, m[1]});
      clear_all();
    end
    // Lines 4 and 5 share a pin with 5 masked; glitch on line 1; aux lines
    cyc(1);
    sel[13:7] <= 7'h14;
    sel[34:28] <= 7'h09;
    sel[41:35] <= 7'h09;
    trig <= 38'h0C00000504;
    aux <= 3'h3;
    pins.set_pin(9, 1'b1);
    pins.short_pulse(20);
    cyc(5);
    #1;
    chk(pend, 19'h20012);
    clear_all();
    cyc(1);
    aux <= 3'h0;
    pins.set_pin(9, 1'b0);
    cyc(5);
    #1;
    chk(pend, 19'h20000);
    clear_all();
    // Software hits racing a clear; lines 3 and 5 masked on one path each
    cyc(1);
    sw <= 19'h40028;
    clr <= 19'h40028;
    emask <= 19'h7FFF7;
    cyc(1);
    sw <= 19'h00000;
    clr <= 19'h00000;
    #1;
    chk(pend, 19'h40008);
    chk(evt, 19'h40020);
    chk({18'h0, irq}, 19'h00001);
    cyc(1);
    #1;
    chk(evt, 19'h00000);
    clear_all();
    finish_test();
  end
endmodule
